// File: common/eeprom_link_if.sv
// four-wire link between serial master and eeprom device
`timescale 1ns/100ps
`default_nettype none

interface eeprom_link_if;
	logic cs;
	logic sclk;
	logic serial_in;
	logic do_bit;
	logic do_oe;
	logic do_line;

	// undriven output line reads high, as with a pull-up
	assign do_line = do_oe ? do_bit : 1'b1;

	modport device (
		input  cs,
		input  sclk,
		input  serial_in,
		output do_bit,
		output do_oe
	);

	modport master (
		output cs,
		output sclk,
		output serial_in,
		input  do_line
	);
endinterface

`default_nettype wire

// File: common/eeprom_params.svh
// constants shared by both ends of the serial eeprom link
`ifndef EEPROM_PARAMS_SVH
`define EEPROM_PARAMS_SVH

`define EE_DEPTH        9'h100
`define EE_ERASED       8'hff
`define EE_HDR_BITS     5'h0c
`define EE_FULL_BITS    5'h14
`define EE_OP_SPECIAL   2'h0
`define EE_OP_WRITE     2'h1
`define EE_OP_READ      2'h2
`define EE_SUB_DISABLE  2'h0
`define EE_SUB_WRITE_ALL 2'h1
`define EE_SUB_ENABLE   2'h3
`define EE_CLK_MHZ      200
`define EE_PROG_TIME_NS 4000
`define EE_PROG_CYCLES  ((`EE_PROG_TIME_NS * `EE_CLK_MHZ) / 1000)
`define EE_CS_LOW_NS    250
`define EE_CS_LOW_CYCLES (((`EE_CS_LOW_NS * `EE_CLK_MHZ) + 999) / 1000)
`define EE_SCLK_HALF    4'h8
`define EE_POLL_SETTLE  6'h10

`endif

// File: common/eeprom_pkg.sv
// types shared by both ends of the serial eeprom link
`include "eeprom_params.svh"

package eeprom_pkg;

	typedef enum logic [1:0] {
		DS_IDLE = 2'h0,
		DS_CMD  = 2'h1,
		DS_READ = 2'h3,
		DS_DONE = 2'h2
	} dev_state_t;

	typedef enum logic [2:0] {
		MS_IDLE  = 3'h0,
		MS_SHIFT = 3'h1,
		MS_CSLOW = 3'h3,
		MS_POLL  = 3'h2,
		MS_GAP   = 3'h6,
		MS_READ  = 3'h5
	} mst_state_t;

	typedef enum logic [2:0] {
		CMD_READ      = 3'h0,
		CMD_WRITE     = 3'h1,
		CMD_WRITE_ALL = 3'h2,
		CMD_ENABLE    = 3'h3,
		CMD_DISABLE   = 3'h4
	} cmd_t;

	typedef struct packed {
		logic [2:0]  cs_s;
		logic [2:0]  ck_s;
		logic [2:0]  sin_s;
		logic        cs_f;
		logic        ck_f;
		logic        sin_f;
		dev_state_t  st;
		logic [4:0]  cnt;
		logic [18:0] sh;
		logic [7:0]  addr;
		logic [7:0]  rd_sh;
		logic [2:0]  rd_bit;
		logic        pen;
		logic        do_q;
		logic        oe_q;
		logic        poll;
		logic        busy;
		logic        all;
		logic [1:0]  ph;
		logic [11:0] tmr;
		logic [7:0]  wa;
		logic [7:0]  wd;
		logic [7:0]  sw;
	} dev_reg_t;

	typedef struct packed {
		mst_state_t  st;
		logic [2:0]  do_s;
		logic        do_f;
		logic        cs;
		logic        ck;
		logic        sdo;
		logic [3:0]  div;
		logic [19:0] tx;
		logic [4:0]  nb;
		logic [4:0]  tot;
		cmd_t        op;
		logic [5:0]  wt;
		logic        skip;
		logic [2:0]  rb;
		logic [7:0]  rx;
		logic [7:0]  words;
		logic        rd_valid;
		logic [7:0]  rd_data;
		logic        done;
		logic        ready;
	} mst_reg_t;

	// three-stage sample: a change counts once stages two and three agree
	function automatic logic settle(input logic [2:0] s, input logic f);
		return (s[1] == s[2]) ? s[2] : f;
	endfunction

endpackage

// File: tb/eeprom_link_checker.sv
// link checker for the serial eeprom ends
`timescale 1ns/100ps
`default_nettype none

module eeprom_link_checker (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// link wires
	input  wire logic cs,
	input  wire logic sclk,
	input  wire logic serial_in,
	input  wire logic do_bit,
	input  wire logic do_oe,
	// device state
	input  wire logic program_enabled,
	input  wire logic busy
);
	logic        sclk_q;
	logic [5:0]  since_q;
	logic [11:0] busy_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// saturating count since the last seen link clock rise
	always_ff @(posedge clk) begin
		sclk_q <= sclk;
		if (rst)
			since_q <= 6'h3f;
		else if (sclk && !sclk_q)
			since_q <= 6'h00;
		else if (since_q != 6'h3f)
			since_q <= since_q + 6'h01;
		if (rst || !busy)
			busy_q <= 12'h000;
		else
			busy_q <= busy_q + 12'h001;
	end

	sequence poll_start;
		$rose(cs) && busy;
	endsequence

	sequence status_low;
		do_oe && !do_bit;
	endsequence

	reset_quiet_a: assert property (disable iff (1'b0) rst |=>
		!cs && !sclk && !do_oe && !program_enabled)
		else $error("link not quiet after reset");
	float_idle_a: assert property (!cs [*6] |-> !do_oe)
		else $error("output driven while deselected");
	pen_select_a: assert property ($changed(program_enabled) |-> cs)
		else $error("protection changed outside a command");
	busy_guard_a: assert property ($rose(busy) |-> program_enabled && cs)
		else $error("program cycle while protected");
	busy_time_a: assert property ($fell(busy) |-> busy_q >= 12'h31f)
		else $error("program cycle too short");
	poll_busy_a: assert property (poll_start |-> ##[1:6] status_low)
		else $error("no busy status on select rise");
	poll_ready_a: assert property ($fell(busy) && cs |->
		##[1:6] (do_oe && do_bit))
		else $error("no ready status after cycle");
	busy_status_a: assert property (busy && do_oe |-> !do_bit)
		else $error("ready shown while busy");
	read_edge_a: assert property (do_oe && $past(do_oe) && $changed(do_bit)
		&& since_q < 6'h10 |-> since_q inside {[6'h01:6'h06]})
		else $error("read bit moved off the clock rise");
	dummy_zero_a: assert property ($rose(do_oe) && since_q < 6'h10
		|-> !do_bit)
		else $error("read did not lead with zero");

	start_seen_c: cover property (cs && serial_in && sclk && !sclk_q);
endmodule

`default_nettype wire

// File: tb/serial_eeprom_program_read_control_bench.sv
// bench for the serial eeprom link, both ends in loop
`timescale 1ns/100ps
`default_nettype none

module serial_eeprom_program_read_control_bench
	import eeprom_pkg::*;
();
	logic       clk;
	logic       rst;
	logic       cmd_valid;
	cmd_t       cmd_op;
	logic [7:0] cmd_addr;
	logic [7:0] cmd_wdata;
	logic [7:0] cmd_words;
	logic       cmd_ready;
	logic       rd_valid;
	logic [7:0] rd_data;
	logic       done;
	logic       program_enabled;
	logic       busy;
	logic [7:0] mem [256];
	logic [7:0] exp_q [$];
	logic [7:0] a;
	logic [7:0] v;
	logic       prog_on;
	int         err_total;
	int         checks;

	eeprom_link_if lk ();

	eeprom_master u_eeprom_master (
		.clk       (clk),
		.rst       (rst),
		.lk        (lk),
		.cmd_valid (cmd_valid),
		.cmd_op    (cmd_op),
		.cmd_addr  (cmd_addr),
		.cmd_wdata (cmd_wdata),
		.cmd_words (cmd_words),
		.cmd_ready (cmd_ready),
		.rd_valid  (rd_valid),
		.rd_data   (rd_data),
		.done      (done)
	);

	eeprom_device u_eeprom_device (
		.clk             (clk),
		.rst             (rst),
		.lk              (lk),
		.program_enabled (program_enabled),
		.busy            (busy)
	);

	eeprom_link_checker u_eeprom_link_checker (
		.clk             (clk),
		.rst             (rst),
		.cs              (lk.cs),
		.sclk            (lk.sclk),
		.serial_in       (lk.serial_in),
		.do_bit          (lk.do_bit),
		.do_oe           (lk.do_oe),
		.program_enabled (program_enabled),
		.busy            (busy)
	);

	task automatic chk(input logic ok, input string msg);
		checks++;
		if (ok !== 1'b1) begin
			err_total++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// one command, bounded waits on ready and done
	task automatic run(input cmd_t op, input logic [7:0] ad, wd, n);
		int i;
		i = 0;
		do begin
			@(negedge clk);
			i++;
		end while (cmd_ready !== 1'b1 && i < 30000);
		@(posedge clk);
		cmd_op    <= op;
		cmd_addr  <= ad;
		cmd_wdata <= wd;
		cmd_words <= n;
		cmd_valid <= 1'b1;
		@(posedge clk);
		cmd_valid <= 1'b0;
		do begin
			@(negedge clk);
			i++;
		end while (done !== 1'b1 && i < 30000);
		if (i >= 30000) begin
			chk(1'b0, "command hung");
			print_verdict();
		end
	endtask

	// reference model: writes only take effect while programming is on
	task automatic wr(input cmd_t op, input logic [7:0] ad, d);
		run(op, ad, d, 8'h00);
		if (op == CMD_ENABLE)
			prog_on = 1'b1;
		if (op == CMD_DISABLE)
			prog_on = 1'b0;
		if (prog_on && op == CMD_WRITE_ALL)
			foreach (mem[j])
				mem[j] = d;
		if (prog_on && op == CMD_WRITE)
			mem[ad] = d;
		chk(busy === 1'b0, "busy after done");
		chk(program_enabled === prog_on, "protection state");
	endtask

	task automatic rd(input logic [7:0] ad, n);
		for (int k = 0; k <= n; k++)
			exp_q.push_back(mem[8'(ad + k)]);
		run(CMD_READ, ad, 8'h00, n);
		chk(exp_q.size() == 0, "words missing");
	endtask

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	always @(negedge clk) begin
		if (rd_valid === 1'b1) begin
			if (exp_q.size() == 0)
				chk(1'b0, "extra word");
			else
				chk(rd_data === exp_q.pop_front(), "read word");
		end
	end

	initial begin
		rst       = 1'b1;
		cmd_valid = 1'b0;
		cmd_op    = CMD_READ;
		cmd_addr  = 8'h00;
		cmd_wdata = 8'h00;
		cmd_words = 8'h00;
		prog_on   = 1'b0;
		err_total = 0;
		checks    = 0;
		a         = 8'($urandom(91721));
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(negedge clk);
		chk(program_enabled === 1'b0, "enabled after reset");
		wr(CMD_WRITE_ALL, 8'h00, 8'h5a);
		wr(CMD_ENABLE, 8'h00, 8'h00);
		v = 8'($urandom);
		wr(CMD_WRITE_ALL, 8'h00, v);
		rd(8'hfe, 8'h03);
		repeat (4) begin
			a = 8'($urandom);
			v = 8'($urandom);
			wr(CMD_WRITE, a, v);
			rd(a - 8'h01, 8'h02);
		end
		wr(CMD_DISABLE, 8'h00, 8'h00);
		wr(CMD_WRITE, a, ~v);
		wr(CMD_WRITE_ALL, 8'h00, ~v);
		rd(a, 8'h01);
		print_verdict();
	end
endmodule

`default_nettype wire

// File: verilog/eeprom_device.sv
// serial eeprom device end: command decode, read, write, protection
`timescale 1ns/100ps
`default_nettype none

`include "eeprom_params.svh"

module eeprom_device
	import eeprom_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// link to the master
	eeprom_link_if.device    lk,
	// state seen by the user side
	output logic             program_enabled,
	output logic             busy
);

	dev_reg_t   q;
	dev_reg_t   d;
	logic [7:0] mem [0:255];
	logic       we;
	logic [7:0] wad;
	logic [7:0] wdat;
	logic       cs_n;
	logic       ck_n;
	logic       sin_n;
	logic       rise;
	logic [4:0] cnt_n;
	logic [18:0] sh_n;
	logic [7:0] rd_first;
	logic [7:0] rd_next;

	localparam logic [11:0] PROG_LAST = 12'(`EE_PROG_CYCLES - 1);

	assign rd_first = mem[sh_n[7:0]];
	assign rd_next  = mem[q.addr + 8'h01];

	always_comb begin
		d = q;
		we = 1'b0;
		wad = q.wa;
		wdat = q.wd;
		d.cs_s = {q.cs_s[1:0], lk.cs};
		d.ck_s = {q.ck_s[1:0], lk.sclk};
		d.sin_s = {q.sin_s[1:0], lk.serial_in};
		cs_n = settle(q.cs_s, q.cs_f);
		ck_n = settle(q.ck_s, q.ck_f);
		sin_n = settle(q.sin_s, q.sin_f);
		d.cs_f = cs_n;
		d.ck_f = ck_n;
		d.sin_f = sin_n;
		rise = ck_n & ~q.ck_f;
		cnt_n = q.cnt + 5'h01;
		sh_n = {q.sh[17:0], sin_n};

		// self-timed engine, runs on clk alone with no link clocks
		if (q.busy) begin
			if (!q.all) begin
				d.tmr = q.tmr + 12'h001;
				if (q.tmr == PROG_LAST) begin
					we = 1'b1;
					d.busy = 1'b0;
				end
			end else begin
				unique case (q.ph)
					2'h0: begin
						we = 1'b1;
						wad = q.sw;
						wdat = `EE_ERASED;
						d.sw = q.sw + 8'h01;
						if (q.sw == 8'hff)
							d.ph = 2'h1;
					end
					2'h1: begin
						we = 1'b1;
						wad = q.sw;
						d.sw = q.sw + 8'h01;
						if (q.sw == 8'hff)
							d.ph = 2'h2;
					end
					2'h2: begin
						d.tmr = q.tmr + 12'h001;
						if (q.tmr == PROG_LAST)
							d.busy = 1'b0;
					end
					2'h3: d.busy = 1'b0;
				endcase
			end
		end

		// status shows only after select has been low and comes back
		if (cs_n & ~q.cs_f & q.poll) begin
			d.oe_q = 1'b1;
			// fresh status with the enable, no stale bit from last poll
			d.do_q = ~q.busy;
		end
		if (q.cs_f & q.poll & q.oe_q & (q.st == DS_IDLE))
			d.do_q = ~q.busy;

		if (!cs_n) begin
			if (q.cs_f) begin
				d.oe_q = 1'b0;
				if (!q.busy)
					d.poll = 1'b0;
			end
			d.st = DS_IDLE;
		end else if (rise) begin
			unique case (q.st)
				DS_IDLE: begin
					// start bits are ignored while a cycle is still running
					if (sin_n && !q.busy) begin
						d.st = DS_CMD;
						d.cnt = 5'h01;
						d.sh = '0;
						d.poll = 1'b0;
						d.oe_q = 1'b0;
					end
				end
				DS_CMD: begin
					d.cnt = cnt_n;
					d.sh = sh_n;
					if (cnt_n == `EE_HDR_BITS) begin
						unique case (sh_n[10:9])
							`EE_OP_READ: begin
								d.st = DS_READ;
								d.addr = sh_n[7:0];
								d.rd_sh = rd_first;
								d.rd_bit = 3'h0;
								d.oe_q = 1'b1;
								d.do_q = 1'b0;
							end
							`EE_OP_WRITE: d.st = DS_CMD;
							`EE_OP_SPECIAL: begin
								d.st = DS_DONE;
								if (sh_n[8:7] == `EE_SUB_ENABLE)
									d.pen = 1'b1;
								else if (sh_n[8:7] == `EE_SUB_DISABLE)
									d.pen = 1'b0;
								else if (sh_n[8:7] == `EE_SUB_WRITE_ALL)
									d.st = DS_CMD;
							end
							default: d.st = DS_DONE;
						endcase
					end else if (cnt_n == `EE_FULL_BITS) begin
						d.st = DS_DONE;
						d.wa = sh_n[15:8];
						d.wd = sh_n[7:0];
						if (q.pen) begin
							d.busy = 1'b1;
							d.all = (sh_n[18:17] == `EE_OP_SPECIAL);
							d.ph = 2'h0;
							d.tmr = 12'h000;
							d.sw = 8'h00;
							d.poll = 1'b1;
						end
					end
				end
				DS_READ: begin
					d.do_q = q.rd_sh[7];
					if (q.rd_bit == 3'h7) begin
						d.addr = q.addr + 8'h01;
						d.rd_sh = rd_next;
						d.rd_bit = 3'h0;
					end else begin
						d.rd_sh = {q.rd_sh[6:0], 1'b0};
						d.rd_bit = q.rd_bit + 3'h1;
					end
				end
				DS_DONE: d.st = DS_DONE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// array keeps its contents through reset, as nonvolatile cells do
	always_ff @(posedge clk) begin
		if (we)
			mem[wad] <= wdat;
	end

	assign lk.do_bit = q.do_q;
	assign lk.do_oe = q.oe_q;
	assign program_enabled = q.pen;
	assign busy = q.busy;

endmodule

`default_nettype wire

// File: verilog/eeprom_master.sv
// serial master end: sends commands, reads words, polls status
`timescale 1ns/100ps
`default_nettype none

`include "eeprom_params.svh"

module eeprom_master
	import eeprom_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// link to the device
	eeprom_link_if.master    lk,
	// command request
	input  wire logic        cmd_valid,
	input  wire cmd_t        cmd_op,
	input  wire logic [7:0]  cmd_addr,
	input  wire logic [7:0]  cmd_wdata,
	input  wire logic [7:0]  cmd_words,
	output logic             cmd_ready,
	// answers
	output logic             rd_valid,
	output logic [7:0]       rd_data,
	output logic             done
);

	mst_reg_t q;
	mst_reg_t d;

	localparam logic [5:0] CS_LAST = 6'(`EE_CS_LOW_CYCLES - 1);
	localparam logic [3:0] HALF = `EE_SCLK_HALF;

	always_comb begin
		d = q;
		d.do_s = {q.do_s[1:0], lk.do_line};
		d.do_f = settle(q.do_s, q.do_f);
		d.rd_valid = 1'b0;
		d.done = 1'b0;
		unique case (q.st)
			MS_IDLE: begin
				d.ready = 1'b1;
				if (cmd_valid && q.ready) begin
					d.ready = 1'b0;
					d.cs = 1'b1;
					d.div = 4'h0;
					d.nb = 5'h00;
					d.op = cmd_op;
					d.words = cmd_words;
					d.st = MS_SHIFT;
					d.tot = `EE_HDR_BITS;
					unique case (cmd_op)
						CMD_READ:
							d.tx = {1'b1, `EE_OP_READ, 1'b0, cmd_addr, 8'h00};
						CMD_WRITE: begin
							d.tx = {1'b1, `EE_OP_WRITE, 1'b0, cmd_addr, cmd_wdata};
							d.tot = `EE_FULL_BITS;
						end
						CMD_WRITE_ALL: begin
							d.tx = {1'b1, `EE_OP_SPECIAL, `EE_SUB_WRITE_ALL,
								7'h00, cmd_wdata};
							d.tot = `EE_FULL_BITS;
						end
						CMD_ENABLE:
							d.tx = {1'b1, `EE_OP_SPECIAL, `EE_SUB_ENABLE, 15'h0000};
						default:
							d.tx = {1'b1, `EE_OP_SPECIAL, `EE_SUB_DISABLE,
								15'h0000};
					endcase
				end
			end
			MS_SHIFT: begin
				d.div = q.div + 4'h1;
				if (q.div == 4'h0) begin
					d.sdo = q.tx[19];
					d.tx = {q.tx[18:0], 1'b0};
				end
				if (q.div == HALF)
					d.ck = 1'b1;
				if (q.div == 4'hf) begin
					d.ck = 1'b0;
					d.nb = q.nb + 5'h01;
					if (q.nb + 5'h01 == q.tot) begin
						d.sdo = 1'b0;
						d.wt = 6'h00;
						if (q.op == CMD_READ) begin
							d.st = MS_READ;
							d.skip = 1'b1;
							d.rb = 3'h0;
						end else begin
							d.cs = 1'b0;
							d.st = (q.op == CMD_WRITE || q.op == CMD_WRITE_ALL)
								? MS_CSLOW : MS_GAP;
						end
					end
				end
			end
			MS_READ: begin
				d.div = q.div + 4'h1;
				// sample just before the next rise, when the bit has settled
				if (q.div == HALF - 4'h1) begin
					if (q.skip) begin
						d.skip = 1'b0;
					end else begin
						d.rx = {q.rx[6:0], q.do_f};
						d.rb = q.rb + 3'h1;
						if (q.rb == 3'h7) begin
							d.rd_valid = 1'b1;
							d.rd_data = {q.rx[6:0], q.do_f};
							d.words = q.words - 8'h01;
							if (q.words == 8'h00) begin
								d.cs = 1'b0;
								d.st = MS_GAP;
							end
						end
					end
				end
				if (q.div == HALF && q.st == MS_READ)
					d.ck = 1'b1;
				if (q.div == 4'hf)
					d.ck = 1'b0;
			end
			MS_CSLOW: begin
				d.wt = q.wt + 6'h01;
				if (q.wt == CS_LAST) begin
					d.cs = 1'b1;
					d.wt = 6'h00;
					d.st = MS_POLL;
				end
			end
			MS_POLL: begin
				if (q.wt != `EE_POLL_SETTLE)
					d.wt = q.wt + 6'h01;
				else if (q.do_f) begin
					d.cs = 1'b0;
					d.wt = 6'h00;
					d.st = MS_GAP;
				end
			end
			MS_GAP: begin
				d.wt = q.wt + 6'h01;
				if (q.wt == CS_LAST) begin
					d.st = MS_IDLE;
					d.done = 1'b1;
				end
			end
			default: d.st = MS_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign lk.cs = q.cs;
	assign lk.sclk = q.ck;
	assign lk.serial_in = q.sdo;
	assign cmd_ready = q.ready;
	assign rd_valid = q.rd_valid;
	assign rd_data = q.rd_data;
	assign done = q.done;

endmodule

`default_nettype wire
